/* File: include/mirse_defines.svh */
// constants for the multi-line read and erase sequencer of a serial flash
// assumes a 200 MHz system clock that oversamples the host serial clock
// Notes on behaviour
// - 3B: 1-line address, 8 dummies, 2-line data
// - BB: 2-line address, 2+2 dummies, 2-line data
// - 4-line read opcode needs quad enable set; enhance-mode frames skip the check
// - EB: 4-line address, 2+4 dummies, 4-line data
// - sample on rising, launch on falling edge
// - address advances one per output byte
// - address wraps to zero past top
// - reads rejected while an internal cycle runs
// - chip select high stops data drive
// - enhance mode: next frame starts with address
// - mode bits after address, then dummies, data
// - 2-line: complementary mode pairs keep enhance
// - 2-line: other mode values leave enhance
// - 4-line: complementary nibbles keep enhance
// - 4-line: other mode values leave enhance
// - 20h erases 4K sector, needs write enable
// - sector chosen from address bit 12 up
// - erase only if select rises after address
// - erase timed, in-progress set, then latch cleared
// - protected targets never erased
// - 52h erases 32K block, needs write enable
// - status bits 0,1 are in-progress and latch
`ifndef MIRSE_DEFINES_SVH
`define MIRSE_DEFINES_SVH

`define MIRSE_OP_DUAL_OUT 8'h3b
`define MIRSE_OP_TWO_IO 8'hbb
`define MIRSE_OP_FOUR_IO 8'heb
`define MIRSE_OP_SECTOR_ERASE 8'h20
`define MIRSE_OP_HALF_BLOCK_ERASE 8'h52
`define MIRSE_OP_WRITE_ENABLE 8'h06

`define MIRSE_CMD_CLOCKS 5'h08
`define MIRSE_ADDR_CLOCKS_1 5'h18
`define MIRSE_ADDR_CLOCKS_2 5'h0c
`define MIRSE_ADDR_CLOCKS_4 5'h06
`define MIRSE_MODE_CLOCKS 5'h02
`define MIRSE_DUMMY_DUAL_OUT 5'h08
`define MIRSE_DUMMY_TWO_IO 5'h02
`define MIRSE_DUMMY_FOUR_IO 5'h04
`define MIRSE_END_CLOCKS 5'h01

`define MIRSE_SECTOR_LSB 12
`define MIRSE_HALF_BLOCK_LSB 15
`define MIRSE_PROT_GRAIN 32'h0001_0000

`define MIRSE_ST_WIP 0
`define MIRSE_ST_WEL 1
`define MIRSE_ST_BP_LSB 2
`define MIRSE_ST_QE 6

`define MIRSE_CLK_MHZ 200

`endif

/* File: include/mirse_pkg.sv */
// types shared by the flash read and erase sequencer
// assumes mirse_defines.svh is included by the modules
package mirse_pkg;
    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_MODE = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA = 3'b100,
        ST_ERASE_END = 3'b101,
        ST_WRITE_ENABLE_CMD_END = 3'b110,
        ST_IGNORE = 3'b111
    } mirse_state_e;

    typedef enum logic [1:0] {
        LANE_1 = 2'b00,
        LANE_2 = 2'b01,
        LANE_4 = 2'b10
    } mirse_lanes_e;

    typedef enum logic [2:0] {
        K_DUAL_OUT = 3'b000,
        K_TWO_IO = 3'b001,
        K_FOUR_IO = 3'b010,
        K_SECTOR = 3'b011,
        K_HALF = 3'b100,
        K_WRITE_ENABLE_CMD = 3'b101
    } mirse_kind_e;
endpackage : mirse_pkg

/* File: hw/mirse_erase_timer.sv */
// self-timed erase cycle counter
// assumes a one-cycle start pulse that never comes while busy
`timescale 1ns/1ps
`include "mirse_defines.svh"
module mirse_erase_timer #(
    parameter int SECTOR_CYCLES = 8000,
    parameter int HALF_CYCLES = 24000
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_half,
    output logic o_busy,
    output logic o_done
);
    localparam int MAXC = (HALF_CYCLES > SECTOR_CYCLES) ? HALF_CYCLES : SECTOR_CYCLES;
    localparam int W = $clog2(MAXC + 1);

    if (SECTOR_CYCLES < 2 || HALF_CYCLES < 2) begin : g_bad_len
        $error("erase cycle counts must be at least 2");
    end

    logic [W-1:0] cnt_q;

    // busy spans exactly the chosen count, done pulses as busy falls
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_q <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                cnt_q <= i_half ? W'(HALF_CYCLES - 1) : W'(SECTOR_CYCLES - 1);
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (cnt_q == '0) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule : mirse_erase_timer

/* File: hw/mirse_top.sv */
// serial flash command sequencer: multi-line reads, enhance mode, erases
// assumes serial clock and chip select synchronous, at most 1/4 clock rate;
// memory array sits outside and answers O_MEM_ADDR within one clock
`timescale 1ns/1ps
`include "mirse_defines.svh"
module mirse_top
    import mirse_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int SECTOR_ERASE_TIME_US = 40,
    parameter int HALF_BLOCK_ERASE_TIME_US = 120,
    parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * `MIRSE_CLK_MHZ,
    parameter int HALF_BLOCK_ERASE_CYCLES = HALF_BLOCK_ERASE_TIME_US * `MIRSE_CLK_MHZ
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic [3:0] I_IO,
    output logic [3:0] O_IO,
    output logic [3:0] O_IO_OE,
    input wire logic I_QUAD_ENABLE,
    input wire logic [3:0] I_BLOCK_PROTECT_FIELD,
    input wire logic I_PROTECTION_SELECT,
    input wire logic I_LOCK_HIT,
    output logic [ADDR_W-1:0] O_MEM_ADDR,
    input wire logic [7:0] I_MEM_DATA,
    output logic [ADDR_W-1:0] O_ERASE_BASE,
    output logic O_ERASE_HALF_BLOCK,
    output logic O_WRITE_IN_PROGRESS,
    output logic O_WRITE_ENABLE_LATCH,
    output logic [7:0] O_STATUS
);
    if (ADDR_W < 17 || ADDR_W > 24) begin : g_bad_addr
        $error("ADDR_W must lie between 17 and 24");
    end

    localparam logic [ADDR_W-1:0] ADDR_ONE = 1;

    mirse_state_e state_q;
    mirse_lanes_e lanes_q;
    mirse_kind_e kind_q;
    logic [4:0] cnt_q;
    logic [4:0] phase_len;
    logic [23:0] shift_q;
    logic [23:0] shift_d;
    logic [7:0] cmd_byte;
    logic [7:0] mode_p;
    logic [7:0] dout_q;
    logic [7:0] dbits;
    logic [1:0] slice_q;
    logic [1:0] slice_last;
    logic sclk_q;
    logic cs_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic step_end;
    logic cmd_is_read;
    logic mode_toggle;
    logic enh_q;
    logic enh_wide_q;
    logic half;
    logic prot_hit;
    logic erase_go;
    logic erase_done;
    logic [ADDR_W-1:0] base;

    // upper 64K blocks guarded by the protect field, larger field covers more
    function automatic logic bp_hit(input logic [3:0] bp, input logic [ADDR_W-1:0] a);
        logic [31:0] span;
        logic [31:0] top;
        span = `MIRSE_PROT_GRAIN << (bp - 4'h1);
        top = 32'h0000_0001 << ADDR_W;
        bp_hit = (bp != 4'h0) && ((span >= top) || (32'(a) >= top - span));
    endfunction : bp_hit

    // edges of the oversampled serial clock and chip select
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sclk_q <= I_SCLK;
            cs_q <= I_CS_N;
        end
    end

    assign sclk_rise = I_SCLK && !sclk_q;
    assign sclk_fall = !I_SCLK && sclk_q;
    assign cs_rise = I_CS_N && !cs_q;

    // input shift picks 1, 2 or 4 lines per rising edge
    always_comb begin
        unique case (lanes_q)
            LANE_1: shift_d = {shift_q[22:0], I_IO[0]};
            LANE_2: shift_d = {shift_q[21:0], I_IO[1:0]};
            default: shift_d = {shift_q[19:0], I_IO};
        endcase
    end

    assign cmd_byte = shift_d[7:0];
    assign mode_p = shift_d[7:0];
    assign cmd_is_read = (cmd_byte == `MIRSE_OP_DUAL_OUT) || (cmd_byte == `MIRSE_OP_TWO_IO)
        || (cmd_byte == `MIRSE_OP_FOUR_IO);
    // 4-line needs both nibbles complementary, 2-line only the low pairs
    assign mode_toggle = (kind_q == K_FOUR_IO) ? (mode_p[7:4] == ~mode_p[3:0])
        : (mode_p[3:2] == ~mode_p[1:0]);

    // length of the current phase in serial clocks
    always_comb begin
        phase_len = 5'h00;
        unique case (state_q)
            ST_CMD: phase_len = `MIRSE_CMD_CLOCKS;
            ST_ADDR: begin
                unique case (lanes_q)
                    LANE_1: phase_len = `MIRSE_ADDR_CLOCKS_1;
                    LANE_2: phase_len = `MIRSE_ADDR_CLOCKS_2;
                    default: phase_len = `MIRSE_ADDR_CLOCKS_4;
                endcase
            end
            ST_MODE: phase_len = `MIRSE_MODE_CLOCKS;
            ST_DUMMY: begin
                if (kind_q == K_DUAL_OUT) begin
                    phase_len = `MIRSE_DUMMY_DUAL_OUT;
                end else if (kind_q == K_TWO_IO) begin
                    phase_len = `MIRSE_DUMMY_TWO_IO;
                end else begin
                    phase_len = `MIRSE_DUMMY_FOUR_IO;
                end
            end
            ST_ERASE_END: phase_len = `MIRSE_END_CLOCKS;
            ST_WRITE_ENABLE_CMD_END: phase_len = `MIRSE_END_CLOCKS;
            ST_DATA: phase_len = 5'h00;
            ST_IGNORE: phase_len = 5'h00;
        endcase
    end

    assign step_end = sclk_rise && !I_CS_N && (phase_len != 5'h00)
        && (cnt_q == phase_len - 5'h01);

    // frame sequencer; a deselect resets it, or re-enters at the address
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            state_q <= ST_CMD;
            lanes_q <= LANE_1;
            kind_q <= K_WRITE_ENABLE_CMD;
            cnt_q <= 5'h00;
            shift_q <= 24'h000000;
        end else if (I_CS_N) begin
            cnt_q <= 5'h00;
            shift_q <= 24'h000000;
            if (enh_q) begin
                state_q <= ST_ADDR;
                lanes_q <= enh_wide_q ? LANE_4 : LANE_2;
                kind_q <= enh_wide_q ? K_FOUR_IO : K_TWO_IO;
            end else begin
                state_q <= ST_CMD;
                lanes_q <= LANE_1;
            end
        end else if (sclk_rise) begin
            shift_q <= shift_d;
            cnt_q <= (step_end || phase_len == 5'h00) ? 5'h00 : cnt_q + 5'h01;
            if (step_end) begin
                unique case (state_q)
                    ST_CMD: begin
                        if (cmd_is_read && O_WRITE_IN_PROGRESS) begin
                            state_q <= ST_IGNORE;
                        end else if (cmd_byte == `MIRSE_OP_DUAL_OUT) begin
                            state_q <= ST_ADDR;
                            kind_q <= K_DUAL_OUT;
                        end else if (cmd_byte == `MIRSE_OP_TWO_IO) begin
                            state_q <= ST_ADDR;
                            kind_q <= K_TWO_IO;
                            lanes_q <= LANE_2;
                        end else if (cmd_byte == `MIRSE_OP_FOUR_IO) begin
                            state_q <= I_QUAD_ENABLE ? ST_ADDR : ST_IGNORE;
                            kind_q <= K_FOUR_IO;
                            lanes_q <= LANE_4;
                        end else if ((cmd_byte == `MIRSE_OP_SECTOR_ERASE)
                            || (cmd_byte == `MIRSE_OP_HALF_BLOCK_ERASE)) begin
                            // erase needs the latch and an idle array
                            state_q <= (O_WRITE_ENABLE_LATCH && !O_WRITE_IN_PROGRESS)
                                ? ST_ADDR : ST_IGNORE;
                            kind_q <= (cmd_byte == `MIRSE_OP_SECTOR_ERASE) ? K_SECTOR : K_HALF;
                        end else if (cmd_byte == `MIRSE_OP_WRITE_ENABLE) begin
                            state_q <= O_WRITE_IN_PROGRESS ? ST_IGNORE : ST_WRITE_ENABLE_CMD_END;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        if (kind_q == K_SECTOR || kind_q == K_HALF) begin
                            state_q <= ST_ERASE_END;
                        end else if (kind_q == K_DUAL_OUT) begin
                            state_q <= ST_DUMMY;
                        end else begin
                            state_q <= ST_MODE;
                        end
                    end
                    ST_MODE: state_q <= ST_DUMMY;
                    ST_DUMMY: begin
                        state_q <= ST_DATA;
                        lanes_q <= (kind_q == K_FOUR_IO) ? LANE_4 : LANE_2;
                    end
                    // any clock after the last address bit spoils the frame
                    ST_ERASE_END: state_q <= ST_IGNORE;
                    ST_WRITE_ENABLE_CMD_END: state_q <= ST_IGNORE;
                    ST_DATA: state_q <= ST_DATA;
                    ST_IGNORE: state_q <= ST_IGNORE;
                endcase
            end
        end
    end

    // enhance mode decided by the mode bits, acted on at the next deselect
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            enh_q <= 1'b0;
            enh_wide_q <= 1'b0;
        end else if (state_q == ST_MODE && step_end) begin
            enh_q <= mode_toggle;
            enh_wide_q <= (kind_q == K_FOUR_IO);
        end
    end

    // read address: loaded after the address phase, bumped per output byte
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_MEM_ADDR <= '0;
        end else if (state_q == ST_ADDR && step_end) begin
            O_MEM_ADDR <= shift_d[ADDR_W-1:0];
        end else if (state_q == ST_DATA && sclk_fall && !I_CS_N && slice_q == 2'h0) begin
            O_MEM_ADDR <= O_MEM_ADDR + ADDR_ONE;
        end
    end

    assign slice_last = (lanes_q == LANE_4) ? 2'h1 : 2'h3;
    assign dbits = (slice_q == 2'h0) ? I_MEM_DATA : dout_q;

    // output lanes launch on falling serial edges, msb slice first
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_IO <= 4'h0;
            O_IO_OE <= 4'h0;
            dout_q <= 8'h00;
            slice_q <= 2'h0;
        end else if (I_CS_N) begin
            O_IO_OE <= 4'h0;
            slice_q <= 2'h0;
        end else if (state_q == ST_DATA && sclk_fall) begin
            slice_q <= (slice_q == slice_last) ? 2'h0 : slice_q + 2'h1;
            if (lanes_q == LANE_4) begin
                O_IO <= dbits[7:4];
                O_IO_OE <= 4'hf;
                dout_q <= {dbits[3:0], 4'h0};
            end else begin
                O_IO <= {2'b00, dbits[7:6]};
                O_IO_OE <= 4'h3;
                dout_q <= {dbits[5:0], 2'b00};
            end
        end
    end

    // erase target: low bits dropped, lock or protect field consulted
    assign half = (kind_q == K_HALF);
    assign base = half ? {O_MEM_ADDR[ADDR_W-1:`MIRSE_HALF_BLOCK_LSB], 15'h0000}
        : {O_MEM_ADDR[ADDR_W-1:`MIRSE_SECTOR_LSB], 12'h000};
    assign prot_hit = I_PROTECTION_SELECT ? I_LOCK_HIT
        : bp_hit(I_BLOCK_PROTECT_FIELD, base);
    assign erase_go = cs_rise && (state_q == ST_ERASE_END) && !prot_hit
        && O_WRITE_ENABLE_LATCH && !O_WRITE_IN_PROGRESS;

    // target is held for the array for the whole erase
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_ERASE_BASE <= '0;
            O_ERASE_HALF_BLOCK <= 1'b0;
        end else if (erase_go) begin
            O_ERASE_BASE <= base;
            O_ERASE_HALF_BLOCK <= half;
        end
    end

    // latch: write enable sets, erase completion clears; set wins
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_WRITE_ENABLE_LATCH <= 1'b0;
        end else begin
            if (erase_done) begin
                O_WRITE_ENABLE_LATCH <= 1'b0;
            end
            if (cs_rise && state_q == ST_WRITE_ENABLE_CMD_END) begin
                O_WRITE_ENABLE_LATCH <= 1'b1;
            end
        end
    end

    // status image; bits 0 and 1 only ever follow the hardware flags
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_STATUS <= 8'h00;
        end else begin
            O_STATUS <= 8'h00;
            O_STATUS[`MIRSE_ST_WIP] <= O_WRITE_IN_PROGRESS;
            O_STATUS[`MIRSE_ST_WEL] <= O_WRITE_ENABLE_LATCH;
            O_STATUS[`MIRSE_ST_BP_LSB+3:`MIRSE_ST_BP_LSB] <= I_BLOCK_PROTECT_FIELD;
            O_STATUS[`MIRSE_ST_QE] <= I_QUAD_ENABLE;
        end
    end

    mirse_erase_timer #(
        .SECTOR_CYCLES(SECTOR_ERASE_CYCLES),
        .HALF_CYCLES(HALF_BLOCK_ERASE_CYCLES)
    ) u_timer (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_start(erase_go),
        .i_half(half),
        .o_busy(O_WRITE_IN_PROGRESS),
        .o_done(erase_done)
    );

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    sequence s_cmd_end;
        state_q == ST_CMD && sclk_rise && !I_CS_N && cnt_q == 5'h07;
    endsequence

    // mode bits leave enhance; the frame itself may run on for a while
    sequence s_mode_exit;
        state_q == ST_MODE && step_end && !mode_toggle;
    endsequence

    sequence s_enh_deselect;
        enh_q && $rose(I_CS_N);
    endsequence

    a_quad_gate: assert property (
        s_cmd_end and (cmd_byte == `MIRSE_OP_FOUR_IO && !I_QUAD_ENABLE)
        |=> state_q == ST_IGNORE)
        else $error("4-line read taken without quad enable");

    a_busy_reject: assert property (
        s_cmd_end and (cmd_is_read && O_WRITE_IN_PROGRESS) |=> state_q == ST_IGNORE)
        else $error("read accepted during internal cycle");

    a_cs_release: assert property (I_CS_N |=> O_IO_OE == 4'h0)
        else $error("lines still driven after deselect");

    a_out_on_fall: assert property ($changed(O_IO) |-> $past(sclk_fall))
        else $error("output changed away from a falling edge");

    a_addr_step: assert property (
        state_q == ST_DATA && sclk_fall && !I_CS_N && slice_q == 2'h0
        |=> O_MEM_ADDR == $past(O_MEM_ADDR) + ADDR_ONE)
        else $error("address did not advance by one");

    a_enh_keep: assert property (s_enh_deselect |=> state_q == ST_ADDR)
        else $error("enhance frame did not start at address");

    a_enh_exit: assert property (s_mode_exit |=> !enh_q)
        else $error("enhance mode not left");

    a_enh_off: assert property (!enh_q && $rose(I_CS_N) |=> state_q == ST_CMD)
        else $error("normal frame did not start at opcode");

    a_erase_guard: assert property (
        $rose(O_WRITE_IN_PROGRESS) |-> $past(O_WRITE_ENABLE_LATCH) && !$past(prot_hit)
        && $past(state_q) == ST_ERASE_END)
        else $error("erase started without latch or on protected target");

    a_erase_frame: assert property (
        state_q == ST_ERASE_END && sclk_rise && !I_CS_N |=> state_q == ST_IGNORE)
        else $error("erase frame not dropped on extra clock");

    a_wel_clear: assert property ($fell(O_WRITE_IN_PROGRESS) |=> !O_WRITE_ENABLE_LATCH)
        else $error("latch kept after erase end");

    a_sector_base: assert property (
        erase_go && !half |=> O_ERASE_BASE[11:0] == 12'h000
        && O_ERASE_BASE[ADDR_W-1:12] == $past(O_MEM_ADDR[ADDR_W-1:12]))
        else $error("sector base wrong");
endmodule : mirse_top

/* File: test/mirse_host_model.sv */
// host controller model: drives chip select, serial clock and io lines
// assumes the bench resolves the io wires and calls these tasks in turn
`timescale 1ns/1ps
module mirse_host_model (
    input wire logic i_clk,
    input wire logic [3:0] i_dev_io,
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_io,
    output logic [3:0] o_oe
);
    // idle: deselected, clock parked low, lines released
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
        o_oe = 4'h0;
    end

    // one serial clock; each phase spans at least two system clocks
    task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] r);
        @(posedge i_clk);
        o_io <= v;
        o_oe <= oe;
        // take what the previous fall launched, just ahead of this rise
        #1 r = i_dev_io;
        @(posedge i_clk);
        o_sclk <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_sclk <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask : tick

    // n clocks of w bits each, msb first
    task automatic shift(input int w, input logic [23:0] val, input int n);
        logic [3:0] m;
        logic [3:0] r;
        m = 4'((1 << w) - 1);
        for (int i = n - 1; i >= 0; i--) begin
            tick(4'(val >> (i * w)) & m, m, r);
        end
    endtask : shift

    // one byte in w-bit slices; lines released so the device can drive
    task automatic get(input int w, output logic [7:0] b);
        logic [3:0] r;
        b = 8'h00;
        for (int i = 0; i < 8 / w; i++) begin
            tick(4'h0, 4'h0, r);
            b = 8'((b << w) | (r & 4'((1 << w) - 1)));
        end
    endtask : get

    task automatic sel();
        @(posedge i_clk);
        o_cs_n <= 1'b0;
    endtask : sel

    // raised right after the last clock, then held high a while
    task automatic desel();
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask : desel
endmodule : mirse_host_model

/* File: test/mirse_top_tb.sv */
// self-checking bench for the flash read and erase sequencer
// assumes the design files and the host model are compiled before it
`timescale 1ns/1ps
`include "mirse_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mirse_top_tb;
    localparam int AW = 17;
    localparam int SEC = 20;
    localparam int HALF = 400;
    localparam logic [7:0] K2 [4] = '{8'h03, 8'h06, 8'h09, 8'h0c};
    localparam logic [7:0] X2 [4] = '{8'h00, 8'h05, 8'h0a, 8'h0f};
    localparam logic [7:0] K4 [4] = '{8'ha5, 8'h5a, 8'hf0, 8'h0f};
    localparam logic [7:0] X4 [4] = '{8'hff, 8'h00, 8'haa, 8'h55};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic qe = 1'b0;
    logic [3:0] bp = 4'h0;
    logic psel = 1'b0;
    logic lock = 1'b0;
    logic sclk, cs_n, ehalf, write_in_progress_flag, write_enable_latch, cap_half;
    logic [3:0] h_io, h_oe, io_in, d_io, d_oe;
    logic [AW-1:0] maddr, ebase, cap_base;
    logic [7:0] mdata, stat;
    logic [15:0] rnd = 16'h3428;
    int err_total = 0;
    int checks = 0;
    int wip_cnt = 0;

    initial forever #2.5 clk = ~clk;

    function automatic logic [7:0] ref_byte(input logic [AW-1:0] a);
        return 8'(a[7:0] * 3) ^ a[15:8] ^ {a[16], 7'h11};
    endfunction : ref_byte

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // array answers combinationally; wire level resolved from both drivers
    assign mdata = ref_byte(maddr);
    assign io_in = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & ~h_io);

    // busy length and target captured while the erase runs
    always @(posedge clk) begin
        if (write_in_progress_flag === 1'b1) begin
            wip_cnt <= wip_cnt + 1;
            cap_base <= ebase;
            cap_half <= ehalf;
        end
    end

    mirse_host_model u_host (.i_clk(clk), .i_dev_io(d_io), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_io(h_io), .o_oe(h_oe));

    mirse_top #(.ADDR_W(AW), .SECTOR_ERASE_CYCLES(SEC), .HALF_BLOCK_ERASE_CYCLES(HALF)) uut (
        .I_CLK_SYS(clk), .I_RESET(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_IO(io_in),
        .O_IO(d_io), .O_IO_OE(d_oe), .I_QUAD_ENABLE(qe), .I_BLOCK_PROTECT_FIELD(bp),
        .I_PROTECTION_SELECT(psel), .I_LOCK_HIT(lock), .O_MEM_ADDR(maddr),
        .I_MEM_DATA(mdata), .O_ERASE_BASE(ebase), .O_ERASE_HALF_BLOCK(ehalf),
        .O_WRITE_IN_PROGRESS(write_in_progress_flag), .O_WRITE_ENABLE_LATCH(write_enable_latch), .O_STATUS(stat));

    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // one read frame; op_on low models a frame in enhance mode
    task automatic rd(input bit op_on, input logic [7:0] op, input int w, input logic [23:0] a,
        input logic [7:0] p, input int nb, input bit ok);
        logic [7:0] b;
        logic [3:0] r;
        int dw;
        dw = (w == 4) ? 4 : 2;
        u_host.sel();
        if (op_on) u_host.shift(1, {16'h0, op}, 8);
        u_host.shift(w, a, 24 / w);
        if (w > 1) u_host.shift(w, {16'h0, p}, 2);
        for (int i = 0; i < ((w == 1) ? 8 : (w == 2) ? 2 : 4); i++) u_host.tick(4'h0, 4'h0, r);
        for (int k = 0; k < nb; k++) begin
            u_host.get(dw, b);
            if (ok) `CHK(b, ref_byte(AW'(a + k)))
            `CHK(d_oe, ok ? ((w == 4) ? 4'hf : 4'h3) : 4'h0)
        end
        u_host.desel();
        `CHK(d_oe, 4'h0)
    endtask : rd

    task automatic write_enable_cmd();
        u_host.sel();
        u_host.shift(1, {16'h0, `MIRSE_OP_WRITE_ENABLE}, 8);
        u_host.desel();
        #1 `CHK(write_enable_latch, 1'b1)
    endtask : write_enable_cmd

    // erase frame of nbits address bits; n is the expected busy length
    task automatic ers(input logic [7:0] op, input logic [23:0] a, input int nbits, input int n,
        input logic [AW-1:0] base, input logic half, input logic wel_x);
        int k;
        wip_cnt = 0;
        u_host.sel();
        u_host.shift(1, {16'h0, op}, 8);
        u_host.shift(1, (nbits > 24) ? a : a >> (24 - nbits), nbits);
        u_host.desel();
        repeat (2) @(posedge clk);
        #1 if (n > 0) `CHK(stat[1:0], 2'b11)
        if (half) rd(1, `MIRSE_OP_DUAL_OUT, 1, 24'h0, 8'h00, 2, 0);
        for (k = 0; k < 2000 && write_in_progress_flag !== 1'b0; k++) @(posedge clk);
        if (k == 2000) begin
            err_total++;
            stop_test();
        end
        repeat (3) @(posedge clk);
        #1 `CHK(wip_cnt, n)
        if (n > 0) `CHK({cap_half, cap_base}, {half, base})
        `CHK(write_enable_latch, wel_x)
        `CHK(stat, {1'b0, qe, bp, wel_x, 1'b0})
    endtask : ers

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(1, `MIRSE_OP_DUAL_OUT, 1, 24'h01fffe, 8'h00, 3, 1);
        rd(1, `MIRSE_OP_FOUR_IO, 4, 24'h000100, 8'ha5, 1, 0);
        // each loop iteration opens with an opcode frame, so the exits are proven too
        for (int i = 0; i < 8; i++) begin
            if (i == 4) qe <= 1'b1;
            rnd = lfsr(rnd);
            if (i < 4) rd(1, `MIRSE_OP_TWO_IO, 2, {rnd[7:0], rnd}, K2[i], 2, 1);
            else rd(1, `MIRSE_OP_FOUR_IO, 4, {rnd[7:0], rnd}, K4[i - 4], 2, 1);
            rnd = lfsr(rnd);
            if (i < 4) rd(0, 8'h00, 2, {rnd[7:0], rnd}, X2[i], 1, 1);
            else rd(0, 8'h00, 4, {rnd[7:0], rnd}, X4[i - 4], 1, 1);
        end
        ers(`MIRSE_OP_SECTOR_ERASE, 24'h03abc, 24, 0, 17'h0, 1'b0, 1'b0);
        write_enable_cmd();
        ers(`MIRSE_OP_SECTOR_ERASE, 24'h03abc, 23, 0, 17'h0, 1'b0, 1'b1);
        ers(`MIRSE_OP_SECTOR_ERASE, 24'h03abc, 25, 0, 17'h0, 1'b0, 1'b1);
        bp <= 4'h1;
        ers(`MIRSE_OP_SECTOR_ERASE, 24'h01f123, 24, 0, 17'h0, 1'b0, 1'b1);
        bp <= 4'h0;
        psel <= 1'b1;
        lock <= 1'b1;
        ers(`MIRSE_OP_SECTOR_ERASE, 24'h03abc, 24, 0, 17'h0, 1'b0, 1'b1);
        lock <= 1'b0;
        ers(`MIRSE_OP_SECTOR_ERASE, 24'h03abc, 24, SEC, 17'h03000, 1'b0, 1'b0);
        write_enable_cmd();
        ers(`MIRSE_OP_HALF_BLOCK_ERASE, 24'h0abcd, 24, HALF, 17'h08000, 1'b1, 1'b0);
        stop_test();
    end
endmodule : mirse_top_tb
